// ### hw/stnp_consts.svh
`ifndef STNP_CONSTS_SVH
`define STNP_CONSTS_SVH

// ============================================================
// register byte offsets
`define STNP_ADDR_CTRL      5'h00
`define STNP_ADDR_IDLE      5'h04
`define STNP_ADDR_SEP       5'h08
`define STNP_ADDR_MACLO     5'h0C
`define STNP_ADDR_MACHI     5'h10
`define STNP_ADDR_STAT      5'h14

// ============================================================
// control and status field positions
`define STNP_CTRL_FAST      0
`define STNP_CTRL_SEPEN     1
`define STNP_CTRL_MACEN     2
`define STNP_CTRL_OP_LO     4
`define STNP_CTRL_OP_HI     5
`define STNP_CTRL_LEN_LO    8
`define STNP_CTRL_LEN_HI    10
`define STNP_STAT_BUSY      16

// ============================================================
// writable masks and reset values
`define STNP_CTRL_MASK      32'h00000737
`define STNP_IDLE_MASK      32'h0000FFFF
`define STNP_MACHI_MASK     32'h0000FFFF
`define STNP_CTRL_RST       32'h00000000
`define STNP_IDLE_RST       32'h00000000
`define STNP_SEP_RST        32'h00000000
`define STNP_MAC_RST        32'h00000000

// ============================================================
// timing and sizes
`define STNP_TICK_NS        10000000
`define STNP_CLK_NS         5
`define STNP_HOLD_CYCLES    16
`define STNP_MAX_PKT        512
`define STNP_SEP_MAX        4
`define STNP_MAC_BYTES      6

`endif

// ### hw/stnp_pkg.sv
package stnp_pkg;

// ============================================================
// framer states
typedef enum logic [1:0] {
	ST_COLLECT,
	ST_HOLD,
	ST_SEND,
	ST_MAC
} stnp_state_t;

endpackage : stnp_pkg

// ### hw/stnp_mem_if.sv
`timescale 1ns/1ps

interface stnp_mem_if #(parameter int AW = 9);
	logic          we;
	logic [AW-1:0] waddr;
	logic [7:0]    wdata;
	logic          re;
	logic [AW-1:0] raddr;
	logic [7:0]    rdata;

	modport ctl (output we, waddr, wdata, re, raddr, input rdata);
	modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface : stnp_mem_if

// ### hw/stnp_pkt_mem.sv
`timescale 1ns/1ps

module stnp_pkt_mem #(
	parameter int DEPTH = 512,
	parameter int AW    = 9
) (
	input wire logic clk,
	input wire logic rst_n,
	stnp_mem_if.mem  port
);
	logic [7:0] ram [DEPTH];

	// ============================================================
	// storage, no reset so it maps to block ram
	always_ff @(posedge clk) begin
		if (port.we) begin
			ram[port.waddr] <= port.wdata;
		end
	end

	// ============================================================
	// registered read, held until the next read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port.rdata <= 8'h00;
		end else if (port.re) begin
			port.rdata <= ram[port.raddr];
		end
	end
endmodule : stnp_pkt_mem

// ### hw/stnp_top.sv
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "stnp_consts.svh"

module stnp_top #(
	parameter int DEPTH       = `STNP_MAX_PKT,
	parameter int TICK_CYCLES = `STNP_TICK_NS / `STNP_CLK_NS,
	parameter int HOLD_CYCLES = `STNP_HOLD_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	output logic             rx_ready,
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	output logic             tx_last,
	input  wire logic        tx_ready,
	input  wire logic        conn_open
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	stnp_pkg::stnp_state_t st_ff, nxt_st;

	logic [31:0]   ctrl_ff, idle_ff, sep_ff, maclo_ff, machi_ff;
	logic [31:0]   rdata_ff, rd_val;
	logic          wait_ff;
	logic          rx_ready_ff;
	logic [7:0]    tx_data_ff, skid_data_ff;
	logic          tx_valid_ff, tx_last_ff, skid_v_ff, skid_last_ff;
	logic [CW-1:0] cnt_ff, nxt_cnt, rd_ptr_ff;
	logic          rd_pend_ff, rd_last_ff;
	logic [31:0]   tick_cnt_ff;
	logic          tick_ff;
	logic [15:0]   idle_cnt_ff;
	logic [31:0]   hold_cnt_ff;
	logic [31:0]   hist_ff;
	logic [2:0]    hist_n_ff;
	logic [1:0]    tail_ff;
	logic [2:0]    mac_idx_ff;
	logic          mac_pend_ff, nxt_mac_pend;

	logic          accept, push, pop, issue, done;
	logic          src_v, src_l;
	logic [7:0]    src_d;
	logic          close_byte, close_idle, sep_hit, idle_hit;
	logic [2:0]    sep_len;
	logic [1:0]    sep_op;
	logic [31:0]   hist_now;
	logic [3:0]    sep_ok;
	logic [47:0]   mac48;

	stnp_mem_if #(.AW(AW)) mem_bus ();

	stnp_pkt_mem #(
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clk   (clk),
		.rst_n (rst_n),
		.port  (mem_bus.mem)
	);

	function automatic logic [31:0] stnp_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction : stnp_merge

	// ============================================================
	// register bus: one wait cycle, then the answer
	logic acc_go, wr_go;
	assign acc_go = (avs_read | avs_write) & wait_ff;
	assign wr_go  = avs_write & ~wait_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_ff <= 1'b1;
		end else begin
			wait_ff <= ~acc_go;
		end
	end

	always_comb begin
		rd_val = 32'h00000000;
		if (avs_address == `STNP_ADDR_CTRL) begin
			rd_val = ctrl_ff;
		end else if (avs_address == `STNP_ADDR_IDLE) begin
			rd_val = idle_ff;
		end else if (avs_address == `STNP_ADDR_SEP) begin
			rd_val = sep_ff;
		end else if (avs_address == `STNP_ADDR_MACLO) begin
			rd_val = maclo_ff;
		end else if (avs_address == `STNP_ADDR_MACHI) begin
			rd_val = machi_ff;
		end else if (avs_address == `STNP_ADDR_STAT) begin
			rd_val = 32'(cnt_ff);
			rd_val[`STNP_STAT_BUSY] = (st_ff != stnp_pkg::ST_COLLECT);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 32'h00000000;
		end else if (acc_go) begin
			rdata_ff <= avs_read ? rd_val : 32'h00000000;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff  <= `STNP_CTRL_RST;
			idle_ff  <= `STNP_IDLE_RST;
			sep_ff   <= `STNP_SEP_RST;
			maclo_ff <= `STNP_MAC_RST;
			machi_ff <= `STNP_MAC_RST;
		end else if (wr_go) begin
			// interval below twelve is accepted as written
			if (avs_address == `STNP_ADDR_CTRL) begin
				ctrl_ff <= stnp_merge(ctrl_ff, avs_writedata,
					avs_byteenable) & `STNP_CTRL_MASK;
			end else if (avs_address == `STNP_ADDR_IDLE) begin
				idle_ff <= stnp_merge(idle_ff, avs_writedata,
					avs_byteenable) & `STNP_IDLE_MASK;
			end else if (avs_address == `STNP_ADDR_SEP) begin
				sep_ff <= stnp_merge(sep_ff, avs_writedata,
					avs_byteenable);
			end else if (avs_address == `STNP_ADDR_MACLO) begin
				maclo_ff <= stnp_merge(maclo_ff, avs_writedata,
					avs_byteenable);
			end else if (avs_address == `STNP_ADDR_MACHI) begin
				machi_ff <= stnp_merge(machi_ff, avs_writedata,
					avs_byteenable) & `STNP_MACHI_MASK;
			end
		end
	end

	// ============================================================
	// separator match over the newest bytes
	assign sep_len  = (ctrl_ff[`STNP_CTRL_LEN_HI:`STNP_CTRL_LEN_LO] > 3'd4)
		? 3'd4 : ctrl_ff[`STNP_CTRL_LEN_HI:`STNP_CTRL_LEN_LO];
	assign sep_op   = (ctrl_ff[`STNP_CTRL_OP_HI:`STNP_CTRL_OP_LO] == 2'd3)
		? 2'd2 : ctrl_ff[`STNP_CTRL_OP_HI:`STNP_CTRL_OP_LO];
	assign hist_now = {hist_ff[23:0], rx_data};

	genvar k;
	generate
		for (k = 0; k < `STNP_SEP_MAX; k++) begin : g_sep
			logic [2:0] pos;
			assign pos = sep_len - 3'd1 - 3'(k);
			// newest byte meets the last pattern byte
			assign sep_ok[k] = (3'(k) >= sep_len) ||
				(hist_now[8*k +: 8] == sep_ff[{pos[1:0], 3'b000} +: 8]);
		end
	endgenerate

	// history count keeps a stale match from the last packet out
	assign sep_hit = ctrl_ff[`STNP_CTRL_SEPEN] && (sep_len != 3'd0) &&
		(&sep_ok) && (hist_n_ff + 3'd1 >= sep_len);

	// ============================================================
	// ten millisecond tick and idle count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_ff <= 32'h00000000;
			tick_ff     <= 1'b0;
		end else if (accept && ctrl_ff[`STNP_CTRL_FAST]) begin
			// restart on each byte: exact interval
			tick_cnt_ff <= 32'h00000000;
			tick_ff     <= 1'b0;
		end else if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
			tick_cnt_ff <= 32'h00000000;
			tick_ff     <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
			tick_ff     <= 1'b0;
		end
	end

	// with fast send off the tick runs free: first step may come early, up to one tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt_ff <= 16'h0000;
		end else if (accept || st_ff != stnp_pkg::ST_COLLECT) begin
			idle_cnt_ff <= 16'h0000;
		end else if (tick_ff && idle_cnt_ff != 16'hFFFF) begin
			idle_cnt_ff <= idle_cnt_ff + 16'h0001;
		end
	end

	assign idle_hit = (idle_ff[15:0] != 16'h0000) && (cnt_ff != '0) &&
		(idle_cnt_ff >= idle_ff[15:0]);

	// ============================================================
	// packet close decisions
	assign accept = rx_valid & rx_ready_ff;
	assign close_byte = accept && (
		(idle_ff[15:0] == 16'h0000) ||
		(cnt_ff == CW'(DEPTH - 1)) ||
		(sep_hit && sep_op == 2'd0) ||
		(tail_ff == 2'd1));
	assign close_idle = (st_ff == stnp_pkg::ST_COLLECT) && !accept &&
		idle_hit;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hist_ff   <= 32'h00000000;
			hist_n_ff <= 3'd0;
			tail_ff   <= 2'd0;
		end else if (close_byte) begin
			hist_ff   <= 32'h00000000;
			hist_n_ff <= 3'd0;
			tail_ff   <= 2'd0;
		end else if (accept) begin
			hist_ff <= hist_now;
			if (hist_n_ff != 3'd4) begin
				hist_n_ff <= hist_n_ff + 3'd1;
			end
			if (sep_hit && tail_ff == 2'd0) begin
				tail_ff <= sep_op;
			end else if (tail_ff != 2'd0) begin
				tail_ff <= tail_ff - 2'd1;
			end
		end else if (close_idle) begin
			hist_n_ff <= 3'd0;
			tail_ff   <= 2'd0;
		end
	end

	// ============================================================
	// state machine
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			stnp_pkg::ST_COLLECT: begin
				if (close_byte || close_idle) begin
					nxt_st = ctrl_ff[`STNP_CTRL_FAST] ?
						stnp_pkg::ST_SEND : stnp_pkg::ST_HOLD;
				end else if (mac_pend_ff && cnt_ff == '0) begin
					nxt_st = stnp_pkg::ST_MAC;
				end
			end
			stnp_pkg::ST_HOLD: begin
				if (hold_cnt_ff == 32'(HOLD_CYCLES - 1)) begin
					nxt_st = stnp_pkg::ST_SEND;
				end
			end
			stnp_pkg::ST_SEND: begin
				if (done) begin
					nxt_st = mac_pend_ff ? stnp_pkg::ST_MAC
						: stnp_pkg::ST_COLLECT;
				end
			end
			stnp_pkg::ST_MAC: begin
				if (done) begin
					nxt_st = stnp_pkg::ST_COLLECT;
				end
			end
			default: nxt_st = stnp_pkg::ST_COLLECT;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= stnp_pkg::ST_COLLECT;
		end else begin
			st_ff <= nxt_st;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt_ff <= 32'h00000000;
		end else if (st_ff == stnp_pkg::ST_HOLD) begin
			hold_cnt_ff <= hold_cnt_ff + 32'h00000001;
		end else begin
			hold_cnt_ff <= 32'h00000000;
		end
	end

	// set wins over the clear taken on entry to the address send
	assign nxt_mac_pend = (conn_open && ctrl_ff[`STNP_CTRL_MACEN]) ||
		(mac_pend_ff && st_ff != stnp_pkg::ST_MAC);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mac_pend_ff <= 1'b0;
		end else begin
			mac_pend_ff <= nxt_mac_pend;
		end
	end

	// ============================================================
	// fill count and serial back-pressure
	always_comb begin
		nxt_cnt = cnt_ff;
		if (st_ff == stnp_pkg::ST_SEND && done) begin
			nxt_cnt = '0;
		end else if (accept) begin
			nxt_cnt = cnt_ff + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff      <= '0;
			rx_ready_ff <= 1'b0;
		end else begin
			cnt_ff      <= nxt_cnt;
			rx_ready_ff <= (nxt_st == stnp_pkg::ST_COLLECT) &&
				!(nxt_mac_pend && nxt_cnt == '0);
		end
	end

	// ============================================================
	// packet read out and address bytes
	assign mem_bus.we    = accept;
	assign mem_bus.waddr = cnt_ff[AW-1:0];
	assign mem_bus.wdata = rx_data;
	assign issue = (st_ff == stnp_pkg::ST_SEND) && !rd_pend_ff &&
		(rd_ptr_ff < cnt_ff);
	assign mem_bus.re    = issue;
	assign mem_bus.raddr = rd_ptr_ff[AW-1:0];
	assign mac48 = {machi_ff[15:0], maclo_ff};

	always_comb begin
		src_v = 1'b0;
		src_d = 8'h00;
		src_l = 1'b0;
		if (st_ff == stnp_pkg::ST_MAC) begin
			src_v = 1'b1;
			src_d = mac48[8*(`STNP_MAC_BYTES - 1 - 32'(mac_idx_ff)) +: 8];
			src_l = (mac_idx_ff == 3'(`STNP_MAC_BYTES - 1));
		end else if (st_ff == stnp_pkg::ST_SEND) begin
			src_v = rd_pend_ff;
			src_d = mem_bus.rdata;
			src_l = rd_last_ff;
		end
	end

	assign push = src_v & ~skid_v_ff;
	assign done = push & src_l;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_ff  <= '0;
			rd_pend_ff <= 1'b0;
			rd_last_ff <= 1'b0;
		end else if (issue) begin
			rd_ptr_ff  <= rd_ptr_ff + CW'(1);
			rd_pend_ff <= 1'b1;
			rd_last_ff <= (rd_ptr_ff == cnt_ff - CW'(1));
		end else if (push && st_ff == stnp_pkg::ST_SEND) begin
			rd_pend_ff <= 1'b0;
			if (done) begin
				rd_ptr_ff <= '0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mac_idx_ff <= 3'd0;
		end else if (st_ff != stnp_pkg::ST_MAC || done) begin
			mac_idx_ff <= 3'd0;
		end else if (push) begin
			mac_idx_ff <= mac_idx_ff + 3'd1;
		end
	end

	// ============================================================
	// two-entry buffer toward the network side
	assign pop = tx_valid_ff & tx_ready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_ff  <= 1'b0;
			tx_data_ff   <= 8'h00;
			tx_last_ff   <= 1'b0;
			skid_v_ff    <= 1'b0;
			skid_data_ff <= 8'h00;
			skid_last_ff <= 1'b0;
		end else if (!tx_valid_ff || pop) begin
			if (skid_v_ff) begin
				tx_valid_ff <= 1'b1;
				tx_data_ff  <= skid_data_ff;
				tx_last_ff  <= skid_last_ff;
				skid_v_ff   <= 1'b0;
			end else begin
				tx_valid_ff <= push;
				tx_data_ff  <= src_d;
				tx_last_ff  <= src_l;
			end
		end else if (push) begin
			skid_v_ff    <= 1'b1;
			skid_data_ff <= src_d;
			skid_last_ff <= src_l;
		end
	end

	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign rx_ready        = rx_ready_ff;
	assign tx_data         = tx_data_ff;
	assign tx_valid        = tx_valid_ff;
	assign tx_last         = tx_last_ff;
endmodule : stnp_top

// ### verif/stnp_assertions.sv
`timescale 1ns/1ps
`include "stnp_consts.svh"
// ============================================================
// port checker
module stnp_assertions #(
	parameter int DEPTH       = 512,
	parameter int TICK_CYCLES = 20,
	parameter int HOLD_CYCLES = 16
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_valid,
	input wire logic        rx_ready,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_valid,
	input wire logic        tx_last,
	input wire logic        tx_ready,
	input wire logic        conn_open
);
	logic        fast_ff;
	logic        sep_ff;
	logic        mac_ff;
	logic [15:0] idle_ff;
	int          cnt_ff;
	int          quiet_ff;
	int          rxn_ff;
	logic        wr_ok;
	logic        take;
	logic        rx_take;
	logic        idle_zero;
	assign wr_ok     = avs_write && !avs_waitrequest;
	assign take      = tx_valid && tx_ready;
	assign rx_take   = rx_valid && rx_ready;
	assign idle_zero = idle_ff == 16'h0000;
	// ============================================================
	// shadow of the settings, snooped from completed writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_ff <= 1'b0;
			sep_ff  <= 1'b0;
			mac_ff  <= 1'b0;
		end else if (wr_ok && avs_address == `STNP_ADDR_CTRL) begin
			fast_ff <= avs_writedata[`STNP_CTRL_FAST];
			sep_ff  <= avs_writedata[`STNP_CTRL_SEPEN];
			mac_ff  <= avs_writedata[`STNP_CTRL_MACEN];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_ff <= 16'h0000;
		end else if (wr_ok && avs_address == `STNP_ADDR_IDLE) begin
			idle_ff <= avs_writedata[15:0];
		end
	end
	// ============================================================
	// byte counters; rxn tells a full-buffer close from an idle one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff   <= 0;
			quiet_ff <= 0;
			rxn_ff   <= 0;
		end else begin
			cnt_ff   <= take ? (tx_last ? 0 : cnt_ff + 1) : cnt_ff;
			quiet_ff <= rx_take ? 0 : quiet_ff + 1;
			rxn_ff   <= (take && tx_last) ? 0 : rxn_ff + int'(rx_take);
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ============================================================
	// assertions
	chk_zero_close: assert property (
		idle_zero && rx_take |=> !rx_ready)
		else $error("byte with zero interval did not close packet");
	chk_one_byte: assert property (
		idle_zero && !mac_ff && take |-> tx_last)
		else $error("packet longer than one byte with zero interval");
	chk_fast_send: assert property (
		idle_zero && fast_ff && rx_take |-> ##[1:4] tx_valid)
		else $error("fast send too slow");
	chk_hold_delay: assert property (
		idle_zero && !fast_ff && !mac_ff && rx_take |=> !tx_valid [*8])
		else $error("send delay missing with fast send off");
	chk_pkt_max: assert property (
		take && cnt_ff == DEPTH - 1 |-> tx_last)
		else $error("packet exceeds maximum size");
	chk_mac_send: assert property (
		conn_open && mac_ff && rx_ready && !tx_valid |-> ##[1:8] tx_valid)
		else $error("address not sent after connection");
	chk_tx_stall: assert property (
		tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("stalled byte changed or dropped");
	chk_idle_floor: assert property (
		$rose(tx_valid) && fast_ff && !sep_ff && !mac_ff && !idle_zero &&
		rxn_ff != DEPTH |-> quiet_ff >= int'(idle_ff) * TICK_CYCLES)
		else $error("packet sent before idle interval ran out");
	cov_pkt: cover property (take && tx_last);
	cov_conn: cover property (conn_open && mac_ff);
	cov_zero: cover property (idle_zero && rx_take);
endmodule : stnp_assertions

bind stnp_top stnp_assertions #(.DEPTH(DEPTH), .TICK_CYCLES(TICK_CYCLES),
	.HOLD_CYCLES(HOLD_CYCLES)) u_stnp_assertions (.clk(clk), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
	.tx_ready(tx_ready), .conn_open(conn_open));

// ### verif/stnp_net_sink.sv
`timescale 1ns/1ps
// ============================================================
// network transport model: takes bytes, may stall
module stnp_net_sink (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	input  wire logic       tx_last,
	input  wire logic       slow,
	output logic            tx_ready
);
	logic [7:0] byte_q[$];
	int         len_q[$];
	int         cnt;
	logic [1:0] ph_ff;
	// slow mode accepts one cycle in three, to fill the skid buffer
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_ff    <= 2'h0;
			tx_ready <= 1'b0;
			cnt = 0;
		end else begin
			if (tx_valid && tx_ready) begin
				byte_q.push_back(tx_data);
				cnt++;
				if (tx_last) begin
					len_q.push_back(cnt);
					cnt = 0;
				end
			end
			ph_ff    <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
			tx_ready <= !slow || ph_ff == 2'h1;
		end
	end
endmodule : stnp_net_sink

// ### verif/tb_stnp_top.sv
`timescale 1ns/1ps
`include "stnp_consts.svh"
`define CHK(g, e) cmp((g), (e));
// ============================================================
// bench top
module tb_stnp_top;
	localparam int TICK = 20;
	localparam int HOLD = 16;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  rx_data = 8'h00;
	logic        rx_valid = 1'b0;
	logic        rx_ready;
	logic [7:0]  tx_data;
	logic        tx_valid;
	logic        tx_last;
	logic        tx_ready;
	logic        conn_open = 1'b0;
	logic        slow = 1'b0;
	logic [31:0] rd;
	logic [7:0]  q[$];
	logic [7:0]  s[$];
	int          lat;
	int          bad_count = 0;
	int          checks = 0;
	always #2.5 clk = ~clk;
	stnp_top #(.TICK_CYCLES(TICK), .HOLD_CYCLES(HOLD)) u_stnp_top (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
		.tx_ready(tx_ready), .conn_open(conn_open));
	stnp_net_sink u_stnp_net_sink (.clk(clk), .rst_n(rst_n),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
		.slow(slow), .tx_ready(tx_ready));
	// ============================================================
	// tasks
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %0h exp %0h", $time, g, e);
		end
	endtask : cmp
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			rx_data  <= b[i];
			rx_valid <= 1'b1;
			do @(posedge clk); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		@(posedge clk);
	endtask : send
	task automatic measure();
		lat = 0;
		while (tx_valid !== 1'b1 && lat < 2000) begin
			@(posedge clk);
			lat++;
		end
	endtask : measure
	// waits for one whole packet at the sink, then compares it
	task automatic expect_pkt(input logic [7:0] e[$]);
		int n;
		int len;
		n = 0;
		while (u_stnp_net_sink.len_q.size() == 0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		len = -1;
		if (u_stnp_net_sink.len_q.size() > 0) begin
			len = u_stnp_net_sink.len_q.pop_front();
		end
		`CHK(len, e.size())
		if (len == e.size()) begin
			foreach (e[i]) begin
				`CHK(u_stnp_net_sink.byte_q.pop_front(), e[i])
			end
		end
	endtask : expect_pkt
	task automatic end_sim();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	// ============================================================
	// tests
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int a = 0; a <= 24; a += 4) begin
			bus(1'b0, 5'(a), 32'h00000000);
			`CHK(rd, 32'h00000000)
		end
		bus(1'b1, `STNP_ADDR_CTRL, 32'hFFFFFFFF);
		bus(1'b0, `STNP_ADDR_CTRL, 32'h00000000);
		`CHK(rd, 32'h00000737)
		bus(1'b1, 5'h18, 32'hFFFFFFFF);
		bus(1'b0, 5'h18, 32'h00000000);
		`CHK(rd, 32'h00000000)
		bus(1'b1, `STNP_ADDR_IDLE, 32'hFFFF000C);
		bus(1'b0, `STNP_ADDR_IDLE, 32'h00000000);
		`CHK(rd, 32'h0000000C)
		bus(1'b1, `STNP_ADDR_CTRL, 32'h00000001);
		bus(1'b1, `STNP_ADDR_IDLE, 32'h00000000);
		send('{8'h11, 8'h22, 8'h33});
		expect_pkt('{8'h11});
		expect_pkt('{8'h22});
		expect_pkt('{8'h33});
		send('{8'h44});
		measure();
		`CHK(lat < HOLD, 1'b1)
		expect_pkt('{8'h44});
		bus(1'b1, `STNP_ADDR_CTRL, 32'h00000000);
		send('{8'h55});
		measure();
		`CHK(lat >= HOLD, 1'b1)
		expect_pkt('{8'h55});
		// free tick: the close may come up to one tick early
		bus(1'b1, `STNP_ADDR_IDLE, 32'h00000002);
		send('{8'h77});
		measure();
		`CHK(lat >= TICK + HOLD && lat <= 2 * TICK + HOLD + 8, 1'b1)
		expect_pkt('{8'h77});
		bus(1'b1, `STNP_ADDR_CTRL, 32'h00000001);
		bus(1'b1, `STNP_ADDR_IDLE, 32'h00000002);
		send('{8'h66});
		measure();
		`CHK(lat >= 2 * TICK - 4 && lat <= 2 * TICK + 8, 1'b1)
		expect_pkt('{8'h66});
		// separator 0D 0A; the lone 0A before it must not match
		slow <= 1'b1;
		bus(1'b1, `STNP_ADDR_SEP, 32'h00000A0D);
		s = '{8'h41, 8'h0A, 8'h0D, 8'h0A, 8'h42, 8'h43, 8'h44};
		// operation code 3 behaves as 2
		for (int op = 0; op < 4; op++) begin
			bus(1'b1, `STNP_ADDR_CTRL, 32'h00000203 | (op << 4));
			send(s);
			expect_pkt(s[0:3+op-op/3]);
			expect_pkt(s[4+op-op/3:6]);
		end
		bus(1'b1, `STNP_ADDR_SEP, 32'h04030201);
		bus(1'b1, `STNP_ADDR_CTRL, 32'h00000403);
		s = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
		send(s);
		expect_pkt(s[0:6]);
		expect_pkt('{8'h05});
		// no separator length: only the size limit closes the packet
		bus(1'b1, `STNP_ADDR_CTRL, 32'h00000003);
		q = {};
		for (int i = 0; i < 513; i++) q.push_back(8'(i * 7));
		send(q);
		expect_pkt(q[0:511]);
		expect_pkt(q[512:512]);
		slow <= 1'b0;
		bus(1'b1, `STNP_ADDR_MACLO, 32'h33445566);
		bus(1'b1, `STNP_ADDR_MACHI, 32'h00001122);
		bus(1'b1, `STNP_ADDR_CTRL, 32'h00000005);
		bus(1'b1, `STNP_ADDR_IDLE, 32'h00000000);
		conn_open <= 1'b1;
		@(posedge clk);
		conn_open <= 1'b0;
		expect_pkt('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
		end_sim();
	end
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		end_sim();
	end
endmodule : tb_stnp_top
